// >>> common/sdc_pkg.sv
// constants shared by the conversion timing core
// assumes a single system clock feeds every module
package sdc_pkg;
   // modulator tick every six system clocks
   localparam int MOD_DIV        = 6;
   // modulator ticks per filtered result
   localparam int OSR            = 64;
   // filter order
   localparam int SINC_ORDER     = 5;
   // result width delivered to the host
   localparam int RESULT_W       = 20;
   // accumulator width: 1 + order * log2(osr)
   localparam int ACC_W          = 31;
   // ready line low time, in system clocks
   localparam int READY_LOW_CYC  = 6;
   // nominal system clock and result rate, for reference
   localparam int NOM_CLK_HZ     = 9600000;
   localparam int NOM_RATE_HZ    = 25000;
   localparam int CLK_PER_RESULT = NOM_CLK_HZ / NOM_RATE_HZ;
   // reset values
   localparam logic [2:0] DIV_RST = 3'h0;
   localparam logic [5:0] DEC_RST = 6'h00;
   // decoded gain codes
   typedef enum logic [3:0] {
      GAIN_1 = 4'h1,
      GAIN_2 = 4'h2,
      GAIN_4 = 4'h4,
      GAIN_8 = 4'h8
   } gain_t;
endpackage

// >>> common/stage_if.sv
// interface carrying one integrator or comb stage's data
// assumes producer and consumer share core_clk
`timescale 1ns/100ps
`default_nettype none
interface stage_if #(parameter int W = 31);
   logic [W-1:0] data;
   modport src (output data);
   modport dst (input  data);
endinterface
`default_nettype wire

// >>> rtl/sinc_stage.sv
// one stage of the sinc filter: integrator or comb
// assumes enables come from the core's tick counters
`timescale 1ns/100ps
`default_nettype none
module sinc_stage #(
   parameter int  W     = 31,
   parameter bit  COMB  = 1'b0
) (
   input  wire logic core_clk,
   input  wire logic rst_n,
   input  wire logic en,
   stage_if.dst      din,
   stage_if.src      dout
);
   typedef struct packed {
      logic [W-1:0] acc;
      logic [W-1:0] dly;
   } st_t;
   st_t st_q, st_d;

   // integrator adds, comb differences against last decimated sample
   always_comb
   begin
      st_d = st_q;
      if (en)
      begin
         if (COMB)
         begin
            st_d.acc = din.data - st_q.dly;
            st_d.dly = din.data;
         end
         else
         begin
            st_d.acc = st_q.acc + din.data;   // wraps by design, modular arithmetic
         end
      end
   end

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         st_q <= '0;
      else
         st_q <= st_d;
   end

   assign dout.data = st_q.acc;
endmodule
`default_nettype wire

// >>> rtl/sd_conv_timing.sv
// timing and control core of a single channel delta-sigma converter
// assumes the modulator bit arrives from analog logic outside core_clk
`timescale 1ns/100ps
`default_nettype none
module sd_conv_timing #(
   parameter int MOD_DIV  = sdc_pkg::MOD_DIV,
   parameter int OSR      = sdc_pkg::OSR,
   parameter int RESULT_W = sdc_pkg::RESULT_W
) (
   input  wire logic                core_clk,
   input  wire logic                rst_n,
   input  wire logic                clk_en,
   input  wire logic                mod_bit,
   input  wire logic                gain_sel_msb,
   input  wire logic                gain_sel_lsb,
   output logic                     mod_tick,
   output logic [3:0]               gain,
   output logic [RESULT_W-1:0]      result,
   output logic                     result_ready_n
);
   localparam int ACC_W = sdc_pkg::ACC_W;
   localparam int N     = sdc_pkg::SINC_ORDER;

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   typedef struct packed {
      logic [2:0]          mod_sync;  // three-stage pin synchroniser
      logic                mod_val;   // accepted modulator bit
      logic [2:0]          msb_sync;
      logic [2:0]          lsb_sync;
      logic [2:0]          div;       // modulator prescaler
      logic [5:0]          dec;       // decimation counter
      logic                tick;
      logic                dec_tick;
      logic                load;
      logic [3:0]          gain;
      logic [RESULT_W-1:0] result;
      logic                rdy_n;
      logic [2:0]          rdy_cnt;
   } st_t;
   st_t st_q, st_d;

   logic [ACC_W-1:0] bit_val;
   logic             bit_agree;
   logic [ACC_W-1:0] comb_out;

   // ------------------------------------------------------------
   // filter chain: five integrators at tick rate, five combs decimated
   // ------------------------------------------------------------
   stage_if #(.W(ACC_W)) chain [0:2*N] ();

   // modulator bit maps to +1/-1; accepted value held while sync stages disagree
   assign bit_agree = st_q.mod_sync[1] == st_q.mod_sync[2];
   assign bit_val   = st_q.mod_val ? ACC_W'(1) : {ACC_W{1'b1}};
   assign chain[0].data = bit_val;

   genvar g;
   generate
      for (g = 0; g < 2*N; g++)
      begin : stg
         sinc_stage #(
            .W    (ACC_W),
            .COMB (g >= N)
         ) u_stage (
            .core_clk (core_clk),
            .rst_n    (rst_n),
            .en       (clk_en & ((g < N) ? st_q.tick : st_q.dec_tick)),
            .din      (chain[g]),
            .dout     (chain[g+1])
         );
      end
   endgenerate
   assign comb_out = chain[2*N].data;

   // ------------------------------------------------------------
   // timing, gain decode and output register
   // ------------------------------------------------------------
   always_comb
   begin
      st_d          = st_q;
      st_d.tick     = 1'b0;
      st_d.dec_tick = 1'b0;
      st_d.load     = st_d.dec_tick;
      // pins cross into core_clk over three flops
      st_d.mod_sync = {st_q.mod_sync[1:0], mod_bit};
      st_d.msb_sync = {st_q.msb_sync[1:0], gain_sel_msb};
      st_d.lsb_sync = {st_q.lsb_sync[1:0], gain_sel_lsb};
      // free running prescaler, no trigger needed
      if (st_q.div == 3'(MOD_DIV - 1))
      begin
         st_d.div  = sdc_pkg::DIV_RST;
         st_d.tick = 1'b1;
      end
      else
         st_d.div  = st_q.div + 3'h1;
      // decimation counts modulator ticks
      if (st_q.tick)
      begin
         if (st_q.dec == 6'(OSR - 1))
         begin
            st_d.dec      = sdc_pkg::DEC_RST;
            st_d.dec_tick = 1'b1;
         end
         else
            st_d.dec = st_q.dec + 6'h01;
      end
      // combs settle one cycle after dec_tick; load the next cycle
      st_d.load = st_q.dec_tick;
      if (st_q.load)
      begin
         st_d.result  = comb_out[ACC_W-1 -: RESULT_W];
         st_d.rdy_n   = 1'b0;
         st_d.rdy_cnt = 3'(sdc_pkg::READY_LOW_CYC - 1);
      end
      else if (!st_q.rdy_n)
      begin
         // low pulse returns high so every word gives a fresh falling edge
         if (st_q.rdy_cnt == 3'h0)
            st_d.rdy_n = 1'b1;
         else
            st_d.rdy_cnt = st_q.rdy_cnt - 3'h1;
      end
      // gain changes only when the last two sync stages agree
      if (st_q.msb_sync[1] == st_q.msb_sync[2] && st_q.lsb_sync[1] == st_q.lsb_sync[2])
      begin
         case ({st_q.msb_sync[2], st_q.lsb_sync[2]})
            2'b00:   st_d.gain = sdc_pkg::GAIN_1;
            2'b01:   st_d.gain = sdc_pkg::GAIN_2;
            2'b10:   st_d.gain = sdc_pkg::GAIN_4;
            default: st_d.gain = sdc_pkg::GAIN_8;
         endcase
      end
      // a half-settled pin edge is not taken until two stages match
      if (bit_agree)
         st_d.mod_val = st_q.mod_sync[2];
   end

   // counters clear at reset for deterministic result timing
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st_q       <= '0;
         st_q.gain  <= sdc_pkg::GAIN_1;
         st_q.rdy_n <= 1'b1;
      end
      else if (clk_en)
         st_q <= st_d;
   end

   assign mod_tick       = st_q.tick;
   assign gain           = st_q.gain;
   assign result         = st_q.result;
   assign result_ready_n = st_q.rdy_n;
endmodule
`default_nettype wire

// >>> testbench/sdc_checker.sv
// port checker for the conversion timing core
// assumes clk_en stays high, so no freeze breaks the counts
`timescale 1ns/100ps
`default_nettype none
module sdc_checker #(parameter int RESULT_W = 20) (
   input wire logic                core_clk,
   input wire logic                rst_n,
   input wire logic                clk_en,
   input wire logic                mod_bit,
   input wire logic                gain_sel_msb,
   input wire logic                gain_sel_lsb,
   input wire logic                mod_tick,
   input wire logic [3:0]          gain,
   input wire logic [RESULT_W-1:0] result,
   input wire logic                result_ready_n
);
   // ----
   // timing and decode properties
   // ----
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   a_tick_gap: assert property (mod_tick |=> !mod_tick [*5] ##1 mod_tick)
      else $error("modulator tick spacing wrong");
   a_ready_low: assert property ($fell(result_ready_n) |-> !result_ready_n [*6] ##1 result_ready_n)
      else $error("ready low time wrong");
   a_result_period: assert property ($fell(result_ready_n) |-> ##[384:384] $fell(result_ready_n))
      else $error("result period wrong");
   a_load_with_ready: assert property ($changed(result) |-> $fell(result_ready_n))
      else $error("result changed without ready");
   a_fall_after_tick: assert property ($fell(result_ready_n) |-> $past(mod_tick, 3))
      else $error("ready fell off the tick grid");
   a_gain_decode: assert property ($stable({gain_sel_msb, gain_sel_lsb}) [*5]
      |-> gain == (4'h1 << {gain_sel_msb, gain_sel_lsb}))
      else $error("gain decode wrong");
   a_gain_onehot: assert property ($onehot(gain))
      else $error("gain not one-hot");
   a_first_result: assert property ($rose(rst_n) |-> ##[380:395] $fell(result_ready_n))
      else $error("first result late or early");
endmodule
bind sd_conv_timing sdc_checker #(.RESULT_W(RESULT_W)) chk (.core_clk(core_clk),
   .rst_n(rst_n), .clk_en(clk_en), .mod_bit(mod_bit), .gain_sel_msb(gain_sel_msb),
   .gain_sel_lsb(gain_sel_lsb), .mod_tick(mod_tick), .gain(gain), .result(result),
   .result_ready_n(result_ready_n));
`default_nettype wire

// >>> testbench/host_model.sv
// host side: drives the gain pins, fetches each new result word
// assumes the core's ready line and result bus
`timescale 1ns/100ps
`default_nettype none
module host_model (
   input  wire logic                          core_clk,
   input  wire logic                          result_ready_n,
   input  wire logic [sdc_pkg::RESULT_W-1:0] result,
   input  wire logic [1:0]                    code,
   output logic                               gain_sel_msb,
   output logic                               gain_sel_lsb,
   output logic [sdc_pkg::RESULT_W-1:0]      word
);
   logic ready_q = 1'b1;
   // pins follow the code the bench asks for
   assign {gain_sel_msb, gain_sel_lsb} = code;
   // fetch on the fall only; a held low level is no new word
   always @(posedge core_clk)
   begin
      if (ready_q && !result_ready_n)
         word <= result;
      ready_q <= result_ready_n;
   end
endmodule
`default_nettype wire

// >>> testbench/tb.sv
// self-checking bench for the conversion timing core
// assumes host_model on the far side and the bound checker
`timescale 1ns/100ps
`default_nettype none
module tb;
   logic        core_clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        clk_en = 1'b1;
   logic        mod_bit = 1'b0;
   logic        alt = 1'b0;
   logic [1:0]  code = 2'h0;
   logic        gain_sel_msb, gain_sel_lsb, mod_tick, result_ready_n;
   logic [3:0]  gain;
   logic [19:0] result, word;
   int          fails = 0;
   int          check_count = 0;
   int          n;
   always #5 core_clk = ~core_clk;
   // all -1, or +1/-1 alternating once per modulator tick
   always @(negedge core_clk) mod_bit <= alt & (mod_bit ^ mod_tick);
   sd_conv_timing dut (.core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en),
      .mod_bit(mod_bit), .gain_sel_msb(gain_sel_msb), .gain_sel_lsb(gain_sel_lsb),
      .mod_tick(mod_tick), .gain(gain), .result(result), .result_ready_n(result_ready_n));
   host_model host (.core_clk(core_clk), .result_ready_n(result_ready_n), .result(result),
      .code(code), .gain_sel_msb(gain_sel_msb), .gain_sel_lsb(gain_sel_lsb), .word(word));
   // ----
   // shared tasks
   // ----
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp)
      begin
         fails++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // edges until the next ready fall; bounded so a dead line cannot hang
   task automatic wait_fall(output int k);
      bit hi;
      k = 0;
      hi = 1'b0;
      while (k < 900 && !(hi && result_ready_n === 1'b0))
      begin
         hi |= (result_ready_n === 1'b1);
         @(negedge core_clk);
         k++;
      end
   endtask
   task automatic final_report;
      $display("checks=%0d mismatches=%0d", check_count, fails);
      if (fails == 0 && check_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // ----
   // scenarios
   // ----
   task automatic test_gain;
      for (int i = 0; i < 4; i++)
      begin
         code = i[1:0];
         repeat (6) @(negedge core_clk);
         check(gain, 32'h1 << i);
      end
      $display("test_gain done");
   endtask
   task automatic test_tick;
      n = 0;
      repeat (60) @(negedge core_clk) n += (mod_tick === 1'b1);
      check(n, 10);
      $display("test_tick done");
   endtask
   // settled words: all -1 gives full negative scale, alternating gives zero
   task automatic test_data;
      repeat (12) wait_fall(n);
      repeat (2) @(negedge core_clk);
      check(word, 20'h80000);
      alt = 1'b1;
      repeat (12) wait_fall(n);
      repeat (2) @(negedge core_clk);
      check(word, 20'h00000);
      $display("test_data done");
   endtask
   // mid-run reset, then first result, period and low time
   task automatic test_rate;
      rst_n = 1'b0;
      @(negedge core_clk);
      rst_n = 1'b1;
      wait_fall(n);
      check(n >= 382 && n <= 392, 1);
      wait_fall(n);
      check(n, 384);
      n = 0;
      while (result_ready_n === 1'b0 && n < 50)
      begin
         n++;
         @(negedge core_clk);
      end
      check(n, 6);
      $display("test_rate done");
   endtask
   initial
   begin
      #200000;
      fails++;
      final_report;
   end
   initial
   begin
      repeat (4) @(negedge core_clk);
      rst_n = 1'b1;
      test_gain;
      test_tick;
      test_data;
      test_rate;
      final_report;
   end
endmodule
`default_nettype wire
